// ---- dv/dsd_checker.sv ----
// dsd_checker: port-level timing checks for the serial command decoder
// assumes sync_n high >= 4 clk between frames and faults move only between frames
`timescale 1ns/1ps
`default_nettype none
module dsd_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_n,
  input wire logic serial_data_output_oe,
  input wire logic [15:0] dac_out_a,
  input wire logic [15:0] dac_out_b,
  input wire logic [2:0] range_a,
  input wire logic [2:0] range_b,
  input wire logic power_up_a,
  input wire logic power_up_b,
  input wire logic power_up_ref,
  input wire logic current_clamp_enable,
  input wire logic overtemp_shutdown_enable,
  input wire logic clear_level_select,
  input wire logic serial_output_disable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // reset leaves clamp on, everything else off
  rst_cfg_a:
    assert property ($fell(rst) |-> current_clamp_enable && !overtemp_shutdown_enable
      && !clear_level_select && !serial_output_disable) else $error("cfg reset wrong");
  rst_outs_a:
    assert property ($fell(rst) |-> dac_out_a == '0 && dac_out_b == '0 && range_a == '0
      && range_b == '0 && !power_up_a && !power_up_b && !power_up_ref)
    else $error("output reset wrong");
  oe_idle_a:
    assert property (sync_n [*6] |-> !serial_data_output_oe) else $error("oe outside frame");
  oe_off_a:
    assert property (serial_output_disable && $past(serial_output_disable)
      |-> !serial_data_output_oe) else $error("oe while disabled");
  oe_frame_a:
    assert property ((!sync_n) [*6] |-> serial_data_output_oe || serial_output_disable)
    else $error("oe missing in frame");
  // registers only move once sync_n has been high for the two previous clk
  code_quiet_a:
    assert property ($changed(dac_out_a) || $changed(dac_out_b)
      |-> $past(sync_n, 1) && $past(sync_n, 2)) else $error("code moved in frame");
  cfg_quiet_a:
    assert property ($changed({current_clamp_enable, overtemp_shutdown_enable,
      clear_level_select, serial_output_disable, range_a, range_b})
      |-> $past(sync_n, 1) && $past(sync_n, 2)) else $error("cfg moved in frame");
  pwr_frame_a:
    assert property ((!sync_n) [*4] |-> $stable({power_up_a, power_up_b, power_up_ref}))
    else $error("power moved in frame");
endmodule // dsd_checker
bind dsd_top dsd_checker u_dsd_checker (.clk(clk), .rst(rst), .sync_n(sync_n),
  .serial_data_output_oe(serial_data_output_oe), .dac_out_a(dac_out_a),
  .dac_out_b(dac_out_b), .range_a(range_a), .range_b(range_b), .power_up_a(power_up_a),
  .power_up_b(power_up_b), .power_up_ref(power_up_ref),
  .current_clamp_enable(current_clamp_enable),
  .overtemp_shutdown_enable(overtemp_shutdown_enable),
  .clear_level_select(clear_level_select), .serial_output_disable(serial_output_disable));
`default_nettype wire

// ---- dv/dsd_host.sv ----
// dsd_host: host serial port model shifting frames into the decoder
// assumes calls start on a falling clk edge; sclk idles high
`timescale 1ns/1ps
`default_nettype none
module dsd_host (
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo
);
  // idle: clock parked high, no frame
  initial
  begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  // one bit per sclk fall, msb first
  task automatic xfer(input logic [23:0] fr, input int n, output logic [23:0] rd);
    rd = '0;
    sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = (i < 24) ? fr[i] : 1'b0;
      #100;
      sclk = 1'b0;
      // answer bit moves a few clk after the fall; take it just before the rise
      #100;
      rd = {rd[22:0], sdo};
      sclk = 1'b1;
    end
    #100;
    sync_n = 1'b1;
    // released data line shows the inverse, not a held value
    sdi = ~sdi;
  endtask
endmodule // dsd_host
`default_nettype wire

// ---- dv/tb.sv ----
// tb: frame-level tests of the serial command decoder
// assumes dsd_host drives the serial pins; clear and one overcurrent pin pulse between frames
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check((g) === (e))
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, sync_n, sdi, sdo, sdo_oe;
  logic [15:0] dac_out_a, dac_out_b;
  logic [2:0] range_a, range_b;
  logic pu_a, pu_b, pu_ref, clamp, tsd, clr, sdo_dis;
  logic [23:0] last_rd;
  logic oc_a = 1'b0;
  logic clr_pin_n = 1'b1;
  logic sdo_line;
  int n_fail = 0;
  int n_checks = 0;
  dsd_top #(.CODE_BITS(16)) u_dsd_top (.clk(clk), .rst(rst), .sclk(sclk), .sync_n(sync_n),
    .serial_data_input(sdi), .twos_comp(1'b0), .async_clear_pin_n(clr_pin_n),
    .overcurrent_a(oc_a), .overcurrent_b(1'b0), .overtemp(1'b0),
    .serial_data_output(sdo), .serial_data_output_oe(sdo_oe), .dac_out_a(dac_out_a),
    .dac_out_b(dac_out_b), .range_a(range_a), .range_b(range_b), .power_up_a(pu_a),
    .power_up_b(pu_b), .power_up_ref(pu_ref), .current_clamp_enable(clamp),
    .overtemp_shutdown_enable(tsd), .clear_level_select(clr), .serial_output_disable(sdo_dis));
  dsd_host u_dsd_host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo_line));
  // a released output line shows the inverse of its last value, never stale data
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input bit ok);
    n_checks++;
    if (!ok)
    begin
      n_fail++;
      $display("BAD %0t mismatch", $time);
    end
  endtask
  function automatic logic [23:0] cmd(logic rw, logic [2:0] sel, logic [2:0] ch,
    logic [15:0] d);
    return {rw, 1'b0, sel, ch, d};
  endfunction
  // 8 clk gap leaves room for the 3-4 clk update
  task automatic frame(input logic [23:0] fr, input int n = 24);
    u_dsd_host.xfer(fr, n, last_rd);
    repeat (8) @(negedge clk);
  endtask
  // fault and clear pins move only between frames, held 4 clk for the synchroniser
  task automatic pulse(input bit clr_pin);
    if (clr_pin)
      clr_pin_n = 1'b0;
    else
      oc_a = 1'b1;
    repeat (4) @(negedge clk);
    clr_pin_n = 1'b1;
    oc_a = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [2:0] ch, input logic [15:0] d);
    frame(cmd(1'b0, sel, ch, d));
  endtask
  task automatic rdchk(input logic [2:0] sel, input logic [2:0] ch, input logic [15:0] e);
    frame(cmd(1'b1, sel, ch, 16'h0000));
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_NOP, 16'hffff);
    `CHK(last_rd, {8'h00, e});
  endtask
  // watchdog sized well above the 32 frames of the run
  initial
  begin
    #500000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK({clamp, tsd, clr, sdo_dis}, 4'h8);
    wr(dsd_pkg::SEL_DAC, dsd_pkg::CH_A, 16'h1234);
    `CHK(dac_out_a, 16'h0000);
    rdchk(dsd_pkg::SEL_DAC, dsd_pkg::CH_A, 16'h1234);
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_LOAD, 16'hffff);
    `CHK(dac_out_a, 16'h1234);
    wr(dsd_pkg::SEL_DAC, dsd_pkg::CH_BOTH, 16'habcd);
    wr(dsd_pkg::SEL_DAC, dsd_pkg::CH_B, 16'h5a5a);
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_LOAD, 16'h0000);
    `CHK({dac_out_a, dac_out_b}, {16'habcd, 16'h5a5a});
    // frames one bit short or long must be dropped
    for (int n = 23; n <= 25; n += 2)
    begin
      frame(cmd(1'b0, dsd_pkg::SEL_DAC, dsd_pkg::CH_A, 16'h0f0f), n);
      wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_LOAD, 16'h0000);
      `CHK(dac_out_a, 16'habcd);
    end
    for (int r = 0; r < 6; r++)
    begin
      wr(dsd_pkg::SEL_RANGE, dsd_pkg::CH_A, {13'h1fff, r[2:0]});
      `CHK(range_a, r[2:0]);
    end
    `CHK(range_b, 3'h0);
    wr(dsd_pkg::SEL_POWER, dsd_pkg::CH_A, 16'h0015);
    `CHK({pu_a, pu_b, pu_ref}, 3'h7);
    rdchk(dsd_pkg::SEL_POWER, dsd_pkg::CH_A, 16'h0015);
    wr(dsd_pkg::SEL_RANGE, dsd_pkg::CH_A, 16'h0000);
    wr(dsd_pkg::SEL_RANGE, dsd_pkg::CH_B, 16'h0003);
    // clear level 1: unipolar midscale, bipolar negative full scale
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_CONFIG, 16'h0006);
    pulse(1'b0);
    `CHK({pu_a, pu_b}, 2'h3);
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_CLEAR, 16'hffff);
    `CHK({dac_out_a, dac_out_b}, {16'h8000, 16'h0000});
    // clear level 0: zero volts in either polarity
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_CONFIG, 16'h0000);
    `CHK({clamp, tsd, clr, sdo_dis}, 4'h0);
    pulse(1'b0);
    `CHK({pu_a, pu_b}, 2'h1);
    rdchk(dsd_pkg::SEL_POWER, dsd_pkg::CH_A, 16'h0014);
    wr(dsd_pkg::SEL_DAC, dsd_pkg::CH_BOTH, 16'h1111);
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_CLEAR, 16'h0000);
    `CHK({dac_out_a, dac_out_b}, {16'h0000, 16'h8000});
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_CONFIG, 16'hfffb);
    `CHK({clamp, tsd, clr, sdo_dis}, 4'h7);
    // clear pin at level 1: a unipolar midscale, b bipolar negative full scale
    pulse(1'b1);
    `CHK({dac_out_a, dac_out_b}, {16'h8000, 16'h0000});
    // with the serial output off the host only sees the released line
    frame(cmd(1'b1, dsd_pkg::SEL_CTRL, dsd_pkg::FN_NOP, 16'h0000));
    wr(dsd_pkg::SEL_CTRL, dsd_pkg::FN_NOP, 16'h0000);
    `CHK(sdo_oe, 1'b0);
    `CHK(last_rd, ~{8'h00, 16'h000b});
    complete_run();
  end
endmodule // tb
`default_nettype wire

// ---- hw/dsd_clear_code.sv ----
// dsd_clear_code: picks the clear code for one channel from its range
// purely combinational, used once per channel
`timescale 1ns/1ps
`default_nettype none
module dsd_clear_code #(
  parameter int DW = 16
) (
  input wire logic [2:0] range_code,
  input wire logic clear_level_select,
  input wire logic twos_comp,
  output logic [DW-1:0] code
);
  logic bipolar;
  assign bipolar = range_code >= dsd_pkg::RANGE_BIPOLAR_MIN;
  // 0 v: zero for unipolar, midscale offset or zero twos for bipolar
  always_comb
  begin
    if (!clear_level_select)
      code = (bipolar && !twos_comp) ? dsd_pkg::CODE_MID : dsd_pkg::CODE_ZERO;
    else if (!bipolar)
      code = dsd_pkg::CODE_MID;
    else
      code = twos_comp ? dsd_pkg::CODE_MID : dsd_pkg::CODE_ZERO;
  end
endmodule // dsd_clear_code
`default_nettype wire

// ---- hw/dsd_pkg.sv ----
// dsd_pkg: frame layout, select codes, bit positions and defaults for the serial command decoder
// assumes a 40 MHz core clock and a slow host-driven serial clock
package dsd_pkg;
  localparam int FRAME_BITS = 24;
  localparam int BIT_RW = 23;
  localparam int BIT_ZERO = 22;
  localparam int SEL_HI = 21;
  localparam int SEL_LO = 19;
  localparam int CH_HI = 18;
  localparam int CH_LO = 16;
  localparam int DATA_W = 16;
  localparam int RANGE_W = 3;
  localparam int CFG_W = 4;
  localparam int CNT_W = 5;
  // target select codes
  localparam logic [2:0] SEL_DAC = 3'h0;
  localparam logic [2:0] SEL_RANGE = 3'h1;
  localparam logic [2:0] SEL_POWER = 3'h2;
  localparam logic [2:0] SEL_CTRL = 3'h3;
  // channel address codes
  localparam logic [2:0] CH_A = 3'h0;
  localparam logic [2:0] CH_B = 3'h2;
  localparam logic [2:0] CH_BOTH = 3'h4;
  // control function codes in the channel field
  localparam logic [2:0] FN_NOP = 3'h0;
  localparam logic [2:0] FN_CONFIG = 3'h1;
  localparam logic [2:0] FN_CLEAR = 3'h4;
  localparam logic [2:0] FN_LOAD = 3'h5;
  // configuration bit positions
  localparam int CFG_SDO_DIS = 0;
  localparam int CFG_CLR_SEL = 1;
  localparam int CFG_CLAMP = 2;
  localparam int CFG_TSD = 3;
  localparam logic [3:0] CFG_RESET = 4'h4;
  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam logic [2:0] RANGE_BIPOLAR_MIN = 3'h3;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] POWER_RESET = 16'h0000;
  localparam logic [15:0] POWER_RW_MASK = 16'h0015;
  // power control bit positions
  localparam int PWR_PU_A = 0;
  localparam int PWR_PU_B = 2;
  localparam int PWR_PU_REF = 4;
  localparam int PWR_TSD = 5;
  localparam int PWR_OC_A = 7;
  localparam int PWR_OC_B = 9;
  // idle pin levels, in synchroniser order: sync, sclk, sdi, clear, coding, oc a, oc b, temp
  localparam logic [7:0] PIN_IDLE = 8'hf0;
  // overcurrent limit in clamp mode, informative for the analog side
  localparam int CLAMP_MA = 20;
endpackage

// ---- hw/dsd_sync.sv ----
// dsd_sync: two-flop synchroniser for host pins
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dsd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // dsd_sync
`default_nettype wire

// ---- hw/dsd_top.sv ----
// dsd_top: serial command decoder and register bank of a dual output dac
// assumes host drives sclk, sync_n and serial_data_input; clk is 40 MHz and much faster
// Operation
// - a frame is exactly 24 bits, one bit per serial clock
// - frame bits arrive most significant first
// - layout is rw, zero, 3-bit select, 3-bit channel, 16 data bits
// - rw flag picks read or write; all registers readable, writable except the power alert bits
// - select 000 targets the dac code register of the channel
// - select 001 targets the output range register of the channel
// - select 010 targets the power control register
// - select 011 runs a control function chosen by the channel field
// - channel 000 is a, 010 is b, 100 is both
// - code width 16, 14 or 12 bits, left justified, low bits ignored
// - range write uses data bits 2..0, higher bits ignored
// - control function 000 is a no-op, companion for readback
// - control function 001 writes tsd, clamp, clear level, serial_output_disable
// - control function 100 clears both codes and updates outputs now
// - control function 101 loads input codes into the output registers
// - serial_output_disable bit 1 turns serial output off; default 0
// - clamp enable set keeps channel powered and limits current
// - clamp enable clear powers a channel down on overcurrent
// - thermal shutdown acts only while enabled; default disabled
// - clear level selects 0 v or midscale / negative full scale
`timescale 1ns/1ps
`default_nettype none
module dsd_top #(
  parameter int CODE_BITS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic serial_data_input,
  input wire logic twos_comp,
  input wire logic async_clear_pin_n,
  input wire logic overcurrent_a,
  input wire logic overcurrent_b,
  input wire logic overtemp,
  output logic serial_data_output,
  output logic serial_data_output_oe,
  output logic [15:0] dac_out_a,
  output logic [15:0] dac_out_b,
  output logic [2:0] range_a,
  output logic [2:0] range_b,
  output logic power_up_a,
  output logic power_up_b,
  output logic power_up_ref,
  output logic current_clamp_enable,
  output logic overtemp_shutdown_enable,
  output logic clear_level_select,
  output logic serial_output_disable
);
  // timing model: the host pins are slow against clk, so every pin is seen two clk
  // late and edges are found by comparing the synchronised level with its copy from
  // the previous clk. shift, count and sdo therefore trail the sclk fall by about
  // three clk; a host must keep each sclk phase at least four clk long or bits are
  // lost. a frame is only acted on at the sync rise, never mid-frame, so a host that
  // gives up part way through leaves every register untouched.
  typedef struct packed {
    logic sclk_d;
    logic sync_d;
    logic [dsd_pkg::FRAME_BITS-1:0] shift;
    logic [dsd_pkg::CNT_W-1:0] count;
    logic [dsd_pkg::FRAME_BITS-1:0] readback;
    logic [15:0] in_a;
    logic [15:0] in_b;
    logic [15:0] out_a;
    logic [15:0] out_b;
    logic [2:0] rng_a;
    logic [2:0] rng_b;
    logic [15:0] power;
    logic [3:0] cfg;
    logic sdo;
    logic sdo_oe;
  } dsd_state_t;

  dsd_state_t st_ff;
  dsd_state_t nxt_st;
  logic sclk_s;
  logic sync_s;
  logic sdi_s;
  logic clr_s_n;
  // analog side status and the coding pin are asynchronous to clk as well
  logic twos_s;
  logic oca_s;
  logic ocb_s;
  logic ot_s;
  logic [15:0] clr_code_a;
  logic [15:0] clr_code_b;
  logic [23:0] fr;
  logic [2:0] sel;
  logic [2:0] ch;
  logic [15:0] dat;
  logic [15:0] code_mask;

  // all outside pins pass two flops before use; the reset image matches the idle
  // pin levels, so no false sclk or sync edge is seen right after reset
  dsd_sync #(.W(8), .INIT(dsd_pkg::PIN_IDLE)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({sync_n, sclk, serial_data_input, async_clear_pin_n,
        twos_comp, overcurrent_a, overcurrent_b, overtemp}),
    .q({sync_s, sclk_s, sdi_s, clr_s_n,
        twos_s, oca_s, ocb_s, ot_s})
  );

  dsd_clear_code #(.DW(dsd_pkg::DATA_W)) u_clr_a (
    .range_code(st_ff.rng_a),
    .clear_level_select(st_ff.cfg[dsd_pkg::CFG_CLR_SEL]),
    .twos_comp(twos_s),
    .code(clr_code_a)
  );

  dsd_clear_code #(.DW(dsd_pkg::DATA_W)) u_clr_b (
    .range_code(st_ff.rng_b),
    .clear_level_select(st_ff.cfg[dsd_pkg::CFG_CLR_SEL]),
    .twos_comp(twos_s),
    .code(clr_code_b)
  );

  // field split of the captured frame
  // frame field layout
  assign fr = st_ff.shift;
  assign sel = fr[dsd_pkg::SEL_HI:dsd_pkg::SEL_LO];
  assign ch = fr[dsd_pkg::CH_HI:dsd_pkg::CH_LO];
  assign dat = fr[dsd_pkg::DATA_W-1:0];
  assign code_mask = ~((16'h0001 << (dsd_pkg::DATA_W - CODE_BITS)) - 16'h0001);

  // register contents as read back, aligned in the 24-bit answer frame
  function automatic logic [15:0] read_value(input dsd_state_t s, input logic [2:0] rs,
                                             input logic [2:0] rc);
    logic [15:0] v;
    v = 16'h0000;
    unique case (rs)
      dsd_pkg::SEL_DAC: v = (rc == dsd_pkg::CH_B) ? s.in_b : s.in_a;
      dsd_pkg::SEL_RANGE: v = {13'h0000, (rc == dsd_pkg::CH_B) ? s.rng_b : s.rng_a};
      dsd_pkg::SEL_POWER: v = s.power;
      dsd_pkg::SEL_CTRL: v = {12'h000, s.cfg};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // channel field decode, shared by code and range writes
  // a, b or both
  function automatic logic hits_a(input logic [2:0] c);
    return c == dsd_pkg::CH_A || c == dsd_pkg::CH_BOTH;
  endfunction

  function automatic logic hits_b(input logic [2:0] c);
    return c == dsd_pkg::CH_B || c == dsd_pkg::CH_BOTH;
  endfunction

  // force clear codes into input and output codes; the clear command and the
  // clear pin share it so both always pick the same per-range code
  function automatic dsd_state_t with_clear(input dsd_state_t s, input logic [15:0] ca,
                                            input logic [15:0] cb);
    dsd_state_t r;
    r = s;
    r.in_a = ca;
    r.in_b = cb;
    r.out_a = ca;
    r.out_b = cb;
    return r;
  endfunction

  // next state: shifting, frame decode, clear and fault handling
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sclk_d = sclk_s;
    nxt_st.sync_d = sync_s;
    // msb first shift on sclk falling edge while framed
    if (!sync_s && st_ff.sclk_d && !sclk_s)
    begin
      nxt_st.shift = {st_ff.shift[dsd_pkg::FRAME_BITS-2:0], sdi_s};
      // saturate so an overlong frame can never wrap back to a legal count
      nxt_st.count = (&st_ff.count) ? st_ff.count : st_ff.count + 5'h01;
      // readback data leaves msb first on the same edge
      nxt_st.sdo = st_ff.readback[dsd_pkg::FRAME_BITS-1];
      nxt_st.readback = {st_ff.readback[dsd_pkg::FRAME_BITS-2:0], 1'b0};
    end
    // start of frame resets the bit count
    if (st_ff.sync_d && !sync_s)
      nxt_st.count = '0;
    // act on sync rising edge only with exactly 24 bits
    if (!st_ff.sync_d && sync_s && st_ff.count == 5'(dsd_pkg::FRAME_BITS))
    begin
      // read flag: load answer for next frame
      if (fr[dsd_pkg::BIT_RW])
        nxt_st.readback = {8'h00, read_value(st_ff, sel, ch)};
      else
      begin
        unique case (sel)
          dsd_pkg::SEL_DAC:
          begin
            if (hits_a(ch))
              nxt_st.in_a = dat & code_mask;
            if (hits_b(ch))
              nxt_st.in_b = dat & code_mask;
          end
          // range write, low three bits only
          dsd_pkg::SEL_RANGE:
          begin
            if (hits_a(ch))
              nxt_st.rng_a = dat[dsd_pkg::RANGE_W-1:0];
            if (hits_b(ch))
              nxt_st.rng_b = dat[dsd_pkg::RANGE_W-1:0];
          end
          // power control, alert bits kept read only
          dsd_pkg::SEL_POWER:
            nxt_st.power = (st_ff.power & ~dsd_pkg::POWER_RW_MASK) |
                           (dat & dsd_pkg::POWER_RW_MASK);
          dsd_pkg::SEL_CTRL:
          begin
            unique case (ch)
              dsd_pkg::FN_NOP: nxt_st.cfg = st_ff.cfg;
              dsd_pkg::FN_CONFIG: nxt_st.cfg = dat[dsd_pkg::CFG_W-1:0];
              // clear both channels and update now
              dsd_pkg::FN_CLEAR:
                nxt_st = with_clear(nxt_st, clr_code_a, clr_code_b);
              dsd_pkg::FN_LOAD:
              begin
                nxt_st.out_a = st_ff.in_a;
                nxt_st.out_b = st_ff.in_b;
              end
              default: nxt_st.cfg = st_ff.cfg;
            endcase
          end
          default: nxt_st.cfg = st_ff.cfg;
        endcase
      end
    end
    // async clear pin, synchronised, forces clear codes
    // the pin wins over a frame ending in the same clk, so a held pin always clears
    if (!clr_s_n)
      nxt_st = with_clear(nxt_st, clr_code_a, clr_code_b);
    // overcurrent alert bits follow the synchronised faults; set wins over a host write
    nxt_st.power[dsd_pkg::PWR_OC_A] = oca_s;
    nxt_st.power[dsd_pkg::PWR_OC_B] = ocb_s;
    // power down on overcurrent when clamp is off
    // with clamp on the channel stays powered
    if (!st_ff.cfg[dsd_pkg::CFG_CLAMP] && oca_s)
      nxt_st.power[dsd_pkg::PWR_PU_A] = 1'b0;
    if (!st_ff.cfg[dsd_pkg::CFG_CLAMP] && ocb_s)
      nxt_st.power[dsd_pkg::PWR_PU_B] = 1'b0;
    // thermal shutdown only when enabled; alert is sticky until reset
    if (st_ff.cfg[dsd_pkg::CFG_TSD] && ot_s)
    begin
      nxt_st.power[dsd_pkg::PWR_TSD] = 1'b1;
      nxt_st.power[dsd_pkg::PWR_PU_A] = 1'b0;
      nxt_st.power[dsd_pkg::PWR_PU_B] = 1'b0;
    end
    // serial output drives only when enabled and framed
    nxt_st.sdo_oe = !st_ff.cfg[dsd_pkg::CFG_SDO_DIS] && !sync_s;
  end

  // state register with reset defaults
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.sclk_d <= 1'b1;
      st_ff.sync_d <= 1'b1;
      st_ff.cfg <= dsd_pkg::CFG_RESET;
      st_ff.power <= dsd_pkg::POWER_RESET;
      st_ff.rng_a <= dsd_pkg::RANGE_RESET;
      st_ff.rng_b <= dsd_pkg::RANGE_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state flops
  assign serial_data_output = st_ff.sdo;
  assign serial_data_output_oe = st_ff.sdo_oe;
  assign dac_out_a = st_ff.out_a;
  assign dac_out_b = st_ff.out_b;
  assign range_a = st_ff.rng_a;
  assign range_b = st_ff.rng_b;
  assign power_up_a = st_ff.power[dsd_pkg::PWR_PU_A];
  assign power_up_b = st_ff.power[dsd_pkg::PWR_PU_B];
  assign power_up_ref = st_ff.power[dsd_pkg::PWR_PU_REF];
  assign clear_level_select = st_ff.cfg[dsd_pkg::CFG_CLR_SEL];
  assign current_clamp_enable = st_ff.cfg[dsd_pkg::CFG_CLAMP];
  assign overtemp_shutdown_enable = st_ff.cfg[dsd_pkg::CFG_TSD];
  assign serial_output_disable = st_ff.cfg[dsd_pkg::CFG_SDO_DIS];
endmodule // dsd_top
`default_nettype wire
